// *** core/rim_top.sv ***
`timescale 1ns/10ps
`include "rim_defines.svh"
// Host controller for the raw socket modes of a network controller
module rim_top #(
  parameter int          SOCK_IDX     = 0,         // Socket driven by this controller
  parameter logic [15:0] TX_BASE      = 16'h8000,  // Socket transmit buffer base
  parameter logic [15:0] TX_SIZE      = 16'h0800,  // Transmit buffer size, power of two
  parameter logic [15:0] RX_BASE      = 16'hC000,  // Socket receive buffer base
  parameter logic [15:0] RX_SIZE      = 16'h0800,  // Receive buffer size, power of two
  parameter logic [3:0]  OPEN_RETRIES = 4'h4,      // OPEN retries after the first attempt before giving up
  parameter int          SPI_HALF     = 4          // MCLK cycles per serial half period
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             SPI_SCS_N,
  output logic             SPI_SCLK,
  output logic             SPI_MOSI,
  input  wire logic        SPI_MISO
);
  // Socket register block of the chosen socket
  localparam logic [15:0] SOCK = 16'(`RIM_DEV_SOCK_BASE + 16'(SOCK_IDX) * `RIM_DEV_SOCK_STEP);
  localparam logic [15:0] TX_MASK = TX_SIZE - 16'h0001;
  localparam logic [15:0] RX_MASK = RX_SIZE - 16'h0001;

  rim_spi_if spi ();

  rim_pkg::rim_seq_t state;      // Sequencer phase
  rim_pkg::rim_op_t  op;         // Running operation
  logic [2:0]        step;       // Step inside the operation
  logic [3:0]        tries;      // OPEN retries made
  logic [7:0]        rd;         // Last byte read from the device
  logic              cmd_req;    // Software started an operation
  rim_pkg::rim_op_t  cmd_op;     // Operation asked for
  logic              mac_mode;   // Config: MAC raw instead of IP raw
  logic              filter;     // Config: own address filter
  logic [7:0]        proto;      // Config: IP protocol number
  logic [15:0]       send_len;   // Bytes about to be queued
  logic [7:0]        tx_byte;    // Byte to queue
  logic [15:0]       tx_ptr;     // Local copy of device write pointer
  logic [15:0]       rx_ptr;     // Local copy of device read pointer
  logic [15:0]       tx_free;    // Last transmit free size
  logic [15:0]       rx_size;    // Last received size
  logic [7:0]        rx_byte;    // Last byte fetched from the ring
  logic              open_ok;    // Socket reached the raw-open state
  logic              err;        // Last operation refused or failed
  logic              rx_low;     // MAC raw receive space under the safe mark
  logic              sent;       // Sticky: a send completed
  logic              sent_clr;   // Software write-one to clear
  logic              busy;       // Operation pending or running
  logic [31:0]       wmask;      // Byte lane mask of the write
  logic              finish;     // Evaluation ends the operation
  logic [15:0]       rd16_tx;    // Free size assembled from two reads
  logic [15:0]       rd16_rx;    // Received size assembled from two reads
  logic              cur_we;     // Step access direction
  logic [15:0]       cur_addr;   // Step device address
  logic [7:0]        cur_wdata;  // Step write byte

  assign busy     = (state != rim_pkg::SEQ_IDLE) || cmd_req;
  assign wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign rd16_tx  = {tx_free[15:8], rd};
  assign rd16_rx  = {rx_size[15:8], rd};
  assign spi.ce   = CE;
  assign spi.we   = cur_we;
  assign spi.addr = cur_addr;
  assign spi.wdata = cur_wdata;

  // Serial engine; its pins are flip-flops inside it
  rim_spi #(.HALF(SPI_HALF)) u_spi (
    .MCLK    (MCLK),
    .SYS_RST (SYS_RST),
    .bus     (spi),
    .scs_n   (SPI_SCS_N),
    .sclk    (SPI_SCLK),
    .mosi    (SPI_MOSI),
    .miso    (SPI_MISO)
  );

  // Wishbone slave: ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      cmd_req  <= 1'b0;
      cmd_op   <= rim_pkg::OP_NONE;
      mac_mode <= 1'b0;
      filter   <= 1'b0;
      proto    <= 8'h00;
      send_len <= 16'h0000;
      tx_byte  <= 8'h00;
      sent_clr <= 1'b0;
    end else if (CE) begin
      cmd_req  <= 1'b0;
      sent_clr <= 1'b0;
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
        WB_DAT_O <= 32'h0000_0000;  // Unmapped offsets read zero
        if (WB_WE_I) begin
          case (WB_ADR_I)
            `RIM_REG_CTRL: begin
              // Starting while busy is ignored; status shows busy
              if (!busy && WB_SEL_I[0]) begin
                cmd_req <= 1'b1;
                cmd_op  <= rim_pkg::rim_op_t'(WB_DAT_I[3:0]);
              end
            end
            `RIM_REG_CONFIG: begin
              if (WB_SEL_I[0]) begin
                mac_mode <= WB_DAT_I[0];
                filter   <= WB_DAT_I[1];
              end
              if (WB_SEL_I[1]) begin
                proto <= WB_DAT_I[15:8];
              end
            end
            `RIM_REG_LENGTH: begin
              send_len <= (send_len & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
            end
            `RIM_REG_STATUS: begin
              sent_clr <= WB_SEL_I[0] && WB_DAT_I[`RIM_ST_SENT];
            end
            `RIM_REG_TXDATA: begin
              // Each byte written while not busy queues one byte into the ring
              if (!busy && WB_SEL_I[0]) begin
                tx_byte <= WB_DAT_I[7:0];
                cmd_req <= 1'b1;
                cmd_op  <= rim_pkg::OP_TX_BYTE;
              end
            end
            default: begin
              // Writes elsewhere have no effect
            end
          endcase
        end else begin
          case (WB_ADR_I)
            `RIM_REG_CONFIG:   WB_DAT_O <= {16'h0000, proto, 6'h00, filter, mac_mode};
            `RIM_REG_LENGTH:   WB_DAT_O <= {16'h0000, send_len};
            `RIM_REG_STATUS:   WB_DAT_O <= {27'h0000000, sent, rx_low, err, open_ok, busy};
            `RIM_REG_RXDATA:   WB_DAT_O <= {rx_size, 8'h00, rx_byte};
            `RIM_REG_POINTERS: WB_DAT_O <= {rx_ptr, tx_ptr};
            default:           WB_DAT_O <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Access performed by each step of each operation
  always_comb begin
    cur_we    = 1'b0;
    cur_addr  = SOCK + `RIM_DEV_CMD;
    cur_wdata = 8'h00;
    case (op)
      rim_pkg::OP_OPEN: begin
        case (step)
          3'h0: begin cur_we = 1'b1; cur_addr = SOCK + `RIM_DEV_PROTO; cur_wdata = proto; end
          3'h1: begin
            cur_we    = 1'b1;
            cur_addr  = SOCK + `RIM_DEV_MODE;
            cur_wdata = mac_mode ? (`RIM_MODE_MAC_RAW | (filter ? `RIM_MODE_FILTER : 8'h00))
                                 : `RIM_MODE_IP_RAW;
          end
          3'h2: begin cur_we = 1'b1; cur_wdata = `RIM_CMD_OPEN; end
          3'h3: cur_addr = SOCK + `RIM_DEV_CMD;
          3'h4: cur_addr = SOCK + `RIM_DEV_STATE;
          default: begin cur_we = 1'b1; cur_wdata = `RIM_CMD_CLOSE; end
        endcase
      end
      rim_pkg::OP_CLOSE: begin
        if (step == 3'h0) begin
          cur_we    = 1'b1;
          cur_wdata = `RIM_CMD_CLOSE;
        end else begin
          cur_addr = SOCK + `RIM_DEV_STATE;
        end
      end
      rim_pkg::OP_SEND_BEGIN: begin
        case (step)
          3'h0:    cur_addr = SOCK + `RIM_DEV_TX_FREE;
          3'h1:    cur_addr = SOCK + `RIM_DEV_TX_FREE + 16'h0001;
          3'h2:    cur_addr = SOCK + `RIM_DEV_TX_WR;
          default: cur_addr = SOCK + `RIM_DEV_TX_WR + 16'h0001;
        endcase
      end
      rim_pkg::OP_TX_BYTE: begin
        cur_we    = 1'b1;
        cur_addr  = TX_BASE + (tx_ptr & TX_MASK);
        cur_wdata = tx_byte;
      end
      rim_pkg::OP_SEND_COMMIT: begin
        case (step)
          3'h0: begin cur_we = 1'b1; cur_addr = SOCK + `RIM_DEV_TX_WR; cur_wdata = tx_ptr[15:8]; end
          3'h1: begin cur_we = 1'b1; cur_addr = SOCK + `RIM_DEV_TX_WR + 16'h0001; cur_wdata = tx_ptr[7:0]; end
          3'h2: begin cur_we = 1'b1; cur_wdata = `RIM_CMD_SEND; end
          3'h3: cur_addr = SOCK + `RIM_DEV_EVENT;
          default: begin cur_we = 1'b1; cur_addr = SOCK + `RIM_DEV_EVENT; cur_wdata = `RIM_EVT_SEND_DONE; end
        endcase
      end
      rim_pkg::OP_RX_BEGIN: begin
        case (step)
          3'h0:    cur_addr = SOCK + `RIM_DEV_RX_SIZE;
          3'h1:    cur_addr = SOCK + `RIM_DEV_RX_SIZE + 16'h0001;
          3'h2:    cur_addr = SOCK + `RIM_DEV_RX_RD;
          default: cur_addr = SOCK + `RIM_DEV_RX_RD + 16'h0001;
        endcase
      end
      rim_pkg::OP_RX_BYTE: begin
        cur_addr = RX_BASE + (rx_ptr & RX_MASK);
      end
      rim_pkg::OP_RX_COMMIT: begin
        case (step)
          3'h0: begin cur_we = 1'b1; cur_addr = SOCK + `RIM_DEV_RX_RD; cur_wdata = rx_ptr[15:8]; end
          3'h1: begin cur_we = 1'b1; cur_addr = SOCK + `RIM_DEV_RX_RD + 16'h0001; cur_wdata = rx_ptr[7:0]; end
          3'h2: begin cur_we = 1'b1; cur_wdata = `RIM_CMD_RECEIVE_DONE_COMMAND; end
          default: cur_addr = SOCK + `RIM_DEV_CMD;
        endcase
      end
      default: begin
        // No access when idle
      end
    endcase
  end

  // Does the evaluated step end the operation
  always_comb begin
    finish = 1'b0;
    case (op)
      rim_pkg::OP_OPEN:        finish = (step == 3'h4 && rd == (mac_mode ? `RIM_STATE_MAC_RAW
                                                                           : `RIM_STATE_IP_RAW))
                                        || (step == 3'h5 && tries >= OPEN_RETRIES);
      rim_pkg::OP_CLOSE:       finish = (step == 3'h1 && rd == `RIM_STATE_CLOSED);
      rim_pkg::OP_SEND_BEGIN:  finish = (step == 3'h3);
      rim_pkg::OP_SEND_COMMIT: finish = (step == 3'h4);
      rim_pkg::OP_RX_BEGIN:    finish = (step == 3'h3);
      rim_pkg::OP_RX_COMMIT:   finish = (step == 3'h3 && rd == 8'h00);
      default:                 finish = 1'b1;
    endcase
  end

  // Sequencer: issue, wait for the frame, evaluate, choose the next step
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state     <= rim_pkg::SEQ_IDLE;
      op        <= rim_pkg::OP_NONE;
      step      <= 3'h0;
      tries     <= 4'h0;
      rd        <= 8'h00;
      spi.start <= 1'b0;
      open_ok   <= 1'b0;
      err       <= 1'b0;
    end else if (CE) begin
      spi.start <= 1'b0;
      case (state)
        rim_pkg::SEQ_IDLE: begin
          if (cmd_req) begin
            op    <= cmd_op;
            tries <= 4'h0;
            err   <= 1'b0;
            // Only the byte moves keep the open status
            if (cmd_op != rim_pkg::OP_TX_BYTE && cmd_op != rim_pkg::OP_RX_BYTE) begin
              open_ok <= 1'b0;
            end
            if ((cmd_op == rim_pkg::OP_OPEN && mac_mode && SOCK_IDX != 0) ||
                (cmd_op == rim_pkg::OP_SEND_BEGIN &&
                 (send_len > TX_SIZE || send_len > `RIM_MTU)) ||
                cmd_op == rim_pkg::OP_NONE || cmd_op > rim_pkg::OP_RX_BYTE) begin
              err <= 1'b1;
            end else begin
              // MAC raw needs no protocol number, so skip that write
              step      <= (cmd_op == rim_pkg::OP_OPEN && mac_mode) ? 3'h1 : 3'h0;
              state     <= rim_pkg::SEQ_ISSUE;
              spi.start <= 1'b1;
            end
          end
        end
        rim_pkg::SEQ_ISSUE: begin
          state <= rim_pkg::SEQ_WAIT;
        end
        rim_pkg::SEQ_WAIT: begin
          if (spi.done) begin
            rd    <= spi.rdata;
            state <= rim_pkg::SEQ_EVAL;
          end
        end
        rim_pkg::SEQ_EVAL: begin
          if (finish) begin
            state <= rim_pkg::SEQ_IDLE;
            if (op == rim_pkg::OP_OPEN) begin
              open_ok <= (step == 3'h4);
              err     <= (step != 3'h4);
            end
          end else begin
            state     <= rim_pkg::SEQ_ISSUE;
            spi.start <= 1'b1;
            case (op)
              rim_pkg::OP_OPEN: begin
                if (step == 3'h3) begin
                  step <= (rd == 8'h00) ? 3'h4 : 3'h3;
                end else if (step == 3'h5) begin
                  // Closed after a wrong state: run the whole sequence again
                  tries <= tries + 4'h1;
                  step  <= mac_mode ? 3'h1 : 3'h0;
                end else begin
                  step <= step + 3'h1;
                end
              end
              rim_pkg::OP_SEND_BEGIN: begin
                // Poll free size until the whole send fits
                step <= (step == 3'h1 && rd16_tx < send_len) ? 3'h0 : step + 3'h1;
              end
              rim_pkg::OP_SEND_COMMIT: begin
                // Poll for completion; a raw socket has no timeout path
                step <= (step == 3'h3 && (rd & `RIM_EVT_SEND_DONE) == 8'h00) ? 3'h3 : step + 3'h1;
              end
              rim_pkg::OP_RX_COMMIT: begin
                step <= (step == 3'h3) ? 3'h3 : step + 3'h1;
              end
              default: begin
                // Close polls its state; the rest simply advance
                step <= (op == rim_pkg::OP_CLOSE) ? 3'h1 : step + 3'h1;
              end
            endcase
          end
        end
        default: begin
          state <= rim_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Captured device values and local pointer copies
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_ptr  <= 16'h0000;
      rx_ptr  <= 16'h0000;
      tx_free <= 16'h0000;
      rx_size <= 16'h0000;
      rx_byte <= 8'h00;
      rx_low  <= 1'b0;
    end else if (CE && state == rim_pkg::SEQ_EVAL) begin
      case (op)
        rim_pkg::OP_SEND_BEGIN: begin
          if (step == 3'h0) tx_free[15:8] <= rd;
          if (step == 3'h1) tx_free[7:0]  <= rd;
          if (step == 3'h2) tx_ptr[15:8]  <= rd;
          if (step == 3'h3) tx_ptr[7:0]   <= rd;
        end
        rim_pkg::OP_TX_BYTE: begin
          tx_ptr <= tx_ptr + 16'h0001;
        end
        rim_pkg::OP_RX_BEGIN: begin
          if (step == 3'h0) rx_size[15:8] <= rd;
          if (step == 3'h1) begin
            rx_size[7:0] <= rd;
            // Close to full, partial records may be stored; software must drain
            rx_low <= mac_mode && ((RX_SIZE - rd16_rx) < `RIM_RX_LOW_MARK);
          end
          if (step == 3'h2) rx_ptr[15:8] <= rd;
          if (step == 3'h3) rx_ptr[7:0]  <= rd;
        end
        rim_pkg::OP_RX_BYTE: begin
          // Header, payload and trailing CRC bytes all pass here alike
          rx_byte <= rd;
          rx_ptr  <= rx_ptr + 16'h0001;
        end
        default: begin
          // Nothing captured
        end
      endcase
    end
  end

  // Sticky send completion; a new completion beats a clear in the same cycle
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sent <= 1'b0;
    end else if (CE) begin
      if (state == rim_pkg::SEQ_EVAL && op == rim_pkg::OP_SEND_COMMIT && finish) begin
        sent <= 1'b1;
      end else if (sent_clr) begin
        sent <= 1'b0;
      end
    end
  end
endmodule : rim_top

// *** core/rim_defines.svh ***
`ifndef RIM_DEFINES_SVH
`define RIM_DEFINES_SVH

// Software register byte offsets
`define RIM_REG_CTRL       8'h00
`define RIM_REG_CONFIG     8'h04
`define RIM_REG_LENGTH     8'h08
`define RIM_REG_STATUS     8'h0C
`define RIM_REG_TXDATA     8'h10
`define RIM_REG_RXDATA     8'h14
`define RIM_REG_POINTERS   8'h18
`define RIM_CONFIG_RESET   32'h0000_0000
// Status field positions
`define RIM_ST_BUSY        0
`define RIM_ST_OPEN_OK     1
`define RIM_ST_ERROR       2
`define RIM_ST_RX_LOW      3
`define RIM_ST_SENT        4
// Device socket register map
`define RIM_DEV_SOCK_BASE  16'h4000
`define RIM_DEV_SOCK_STEP  16'h0100
`define RIM_DEV_MODE       16'h0000
`define RIM_DEV_CMD        16'h0001
`define RIM_DEV_EVENT      16'h0002
`define RIM_DEV_STATE      16'h0003
`define RIM_DEV_PROTO      16'h0014
`define RIM_DEV_TX_FREE    16'h0020
`define RIM_DEV_TX_WR      16'h0024
`define RIM_DEV_RX_SIZE    16'h0026
`define RIM_DEV_RX_RD      16'h0028
// Mode, command and state codes
`define RIM_MODE_IP_RAW    8'h03
`define RIM_MODE_MAC_RAW   8'h04
`define RIM_MODE_FILTER    8'h40
`define RIM_CMD_OPEN       8'h01
`define RIM_CMD_CLOSE      8'h10
`define RIM_CMD_SEND       8'h20
`define RIM_CMD_RECEIVE_DONE_COMMAND       8'h40
`define RIM_STATE_CLOSED   8'h00
`define RIM_STATE_IP_RAW   8'h32
`define RIM_STATE_MAC_RAW  8'h42
`define RIM_EVT_SEND_DONE  8'h10
// Sizes in bytes
`define RIM_MTU            16'h05EA
`define RIM_RX_LOW_MARK    16'h05F8
`endif

// *** core/rim_pkg.sv ***
package rim_pkg;
  // Sequencer phases
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT  = 2'b10,
    SEQ_EVAL  = 2'b11
  } rim_seq_t;
  // Operations software may start
  typedef enum logic [3:0] {
    OP_NONE        = 4'b0000,
    OP_OPEN        = 4'b0001,
    OP_CLOSE       = 4'b0010,
    OP_SEND_BEGIN  = 4'b0011,
    OP_SEND_COMMIT = 4'b0100,
    OP_RX_BEGIN    = 4'b0101,
    OP_RX_COMMIT   = 4'b0110,
    OP_TX_BYTE     = 4'b0111,
    OP_RX_BYTE     = 4'b1000
  } rim_op_t;
endpackage : rim_pkg

// *** core/rim_spi_if.sv ***
`timescale 1ns/10ps
// One device register access from sequencer to serial engine
interface rim_spi_if;
  logic        ce;     // Clock enable
  logic        start;  // One-cycle request
  logic        we;     // Write when high
  logic [15:0] addr;   // Device address
  logic [7:0]  wdata;  // Write byte
  logic [7:0]  rdata;  // Read byte
  logic        done;   // One-cycle completion
  modport seq (output ce, start, we, addr, wdata, input rdata, done);
  modport eng (input ce, start, we, addr, wdata, output rdata, done);
endinterface : rim_spi_if

// *** core/rim_spi.sv ***
`timescale 1ns/10ps
// Serial engine: one 40-bit single-byte frame per request, mode 0
module rim_spi #(
  parameter int HALF = 4  // MCLK cycles per serial clock half period
) (
  input  wire logic  MCLK,
  input  wire logic  SYS_RST,
  rim_spi_if.eng     bus,
  output logic       scs_n,
  output logic       sclk,
  output logic       mosi,
  input  wire logic  miso
);
  logic [39:0] frame;     // Outgoing bits, MSB first
  logic [7:0]  rx;        // Incoming bits
  logic [5:0]  bit_cnt;   // Bits completed
  logic [7:0]  div;       // Half period counter
  logic        active;    // Frame in progress
  logic        miso_q1;   // Synchroniser first stage
  logic        miso_q2;   // Synchroniser second stage

  // Data pin arrives from the device clock domain
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      miso_q1 <= 1'b0;
      miso_q2 <= 1'b0;
    end else if (bus.ce) begin
      miso_q1 <= miso;
      miso_q2 <= miso_q1;
    end
  end

  // Frame shifter; sampling at the falling edge leaves 2*HALF-2 cycles of margin
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      frame <= 40'h00_0000_0000; rx <= 8'h00; bit_cnt <= 6'h00; div <= 8'h00;
      active <= 1'b0; scs_n <= 1'b1; sclk <= 1'b0; mosi <= 1'b0;
      bus.done <= 1'b0; bus.rdata <= 8'h00;
    end else if (bus.ce) begin
      bus.done <= 1'b0;
      if (!active) begin
        if (bus.start) begin
          // Address, direction, length one, data
          frame  <= {bus.addr, bus.we, 15'h0001, bus.wdata};
          mosi   <= bus.addr[15];
          scs_n  <= 1'b0;
          active <= 1'b1;
          bit_cnt <= 6'h00;
          div    <= 8'h00;
        end
      end else if (div == 8'(HALF - 1)) begin
        div <= 8'h00;
        if (!sclk) begin
          sclk <= 1'b1;  // Device latches on this edge
        end else begin
          sclk <= 1'b0;
          rx   <= {rx[6:0], miso_q2};
          if (bit_cnt == 6'h27) begin
            active      <= 1'b0;
            scs_n       <= 1'b1;
            mosi        <= 1'b0;
            bus.done    <= 1'b1;
            bus.rdata   <= {rx[6:0], miso_q2};
          end else begin
            bit_cnt <= bit_cnt + 6'h01;
            frame   <= {frame[38:0], 1'b0};
            mosi    <= frame[38];
          end
        end
      end else begin
        div <= div + 8'h01;
      end
    end
  end
endmodule : rim_spi

// *** testbench/rim_top_assertions.sv ***
`timescale 1ns/10ps
// Bus answer and serial framing checks, seen from the top ports only
module rim_top_chk (
  input wire logic MCLK, SYS_RST, CE, WB_CYC_I, WB_STB_I, WB_ACK_O, SPI_SCS_N, SPI_SCLK, SPI_MOSI
);
  logic       p;     // Serial clock one cycle ago
  logic [5:0] bits;  // Rising serial edges seen in this frame
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_req; CE && WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  // Count bits so a short or long frame is caught when select rises
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin p <= 1'b0; bits <= 6'h00; end
    else begin p <= SPI_SCLK; bits <= SPI_SCS_N ? 6'h00 : bits + 6'(SPI_SCLK && !p); end
  end
  chk_ack_due: assert property (s_req |=> WB_ACK_O) else $error("ack late");
  chk_ack_pulse: assert property (WB_ACK_O && CE |=> !WB_ACK_O) else $error("ack too long");
  chk_ce_freeze: assert property (!CE |=> $stable({WB_ACK_O, SPI_SCS_N, SPI_SCLK, SPI_MOSI}))
    else $error("pins moved while frozen");
  chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack unasked");
  chk_frame_bits: assert property ($rose(SPI_SCS_N) |-> bits == 6'h28) else $error("frame not 40 bits");
  chk_frame_gap: assert property ($rose(SPI_SCS_N) |-> SPI_SCS_N [*3]) else $error("frames too close");
  chk_sclk_idle: assert property (SPI_SCS_N |-> !SPI_SCLK) else $error("serial clock while idle");
  chk_mosi_hold: assert property (SPI_SCLK && !SPI_SCS_N |-> $stable(SPI_MOSI)) else $error("data moved");
  chk_reset_idle: assert property ($fell(SYS_RST) |-> SPI_SCS_N && !WB_ACK_O) else $error("not idle");
endmodule : rim_top_chk
bind rim_top rim_top_chk u_chk (.MCLK, .SYS_RST, .CE, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .SPI_SCS_N, .SPI_SCLK,
  .SPI_MOSI);

// *** testbench/rim_dev_model.sv ***
`timescale 1ns/10ps
// Behavioural network controller: socket 0 registers behind a mode 0 serial slave
module rim_dev_model (
  input  wire logic clk,
  input  wire logic scs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0]  m [65536];  // Whole device address space
  logic [39:0] sr;         // Incoming frame
  logic [7:0]  rd;         // Byte being read out
  int          n;          // Bits taken in this frame
  int          refuse = 0; // OPENs still to leave the socket closed
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    m[16'h4020] = 8'h08;  // Whole transmit buffer free
    miso = 1'b0;
  end
  always @(negedge scs_n) n = 0;
  // Sample on rising edge; fetch read data once the address is in
  always @(posedge sclk) begin
    sr = {sr[38:0], mosi};
    n++;
    if (n == 32) rd = m[sr[31:16]];
  end
  // Shift out on falling edge; released line toggles so it is never mistaken for data
  always @(negedge sclk) if (n >= 32 && n < 40) miso <= rd[39-n];
  always @(posedge clk) if (scs_n) miso <= ~miso;
  // Writes act at frame end; no timeout event is ever raised
  always @(posedge scs_n) if (sr[23]) begin
    if (sr[39:24] == 16'h4001) begin
      m[16'h4001] = 8'h00;
      if (sr[7:0] == 8'h01) m[16'h4003] = refuse > 0 ? 8'h00 : m[16'h4000][3:0] == 4'h3 ? 8'h32 :
        m[16'h4000][3:0] == 4'h4 ? 8'h42 : 8'h00;
      if (sr[7:0] == 8'h01 && refuse > 0) refuse--;
      if (sr[7:0] == 8'h10) m[16'h4003] = 8'h00;
      if (sr[7:0] == 8'h20) m[16'h4002] |= 8'h10;
    end
    else if (sr[39:24] == 16'h4002) m[16'h4002] &= ~sr[7:0];
    else m[sr[39:24]] = sr[7:0];
  end
endmodule : rim_dev_model

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`define CHK(n,e,a) begin checked++; if ((a) !== (e)) begin mismatches++; $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
  logic MCLK = 0, SYS_RST = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack, cs_n, sclk, mosi, miso;
  logic [7:0]  adr = 0, pr, b [16];
  logic [31:0] dat = 0, rdat, q;
  int          mismatches = 0, checked = 0, cnt = 0, len, i;
  rim_top u_dut (.MCLK, .SYS_RST, .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_DAT_I(dat), .WB_SEL_I(4'hF), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SPI_SCS_N(cs_n), .SPI_SCLK(sclk),
    .SPI_MOSI(mosi), .SPI_MISO(miso));
  rim_dev_model u_dev (.clk(MCLK), .scs_n(cs_n), .sclk, .mosi, .miso);
  initial forever #12.5 MCLK = ~MCLK;
  // Enable drops for one cycle at most, so a held ack is gone before the next request is sampled
  always @(posedge MCLK) ce <= !ce || $urandom_range(0, 7) != 0;
  // About 90 frames of 370 cycles are expected; a stuck poll ends here
  always @(posedge MCLK) if (++cnt > 60000) begin mismatches++; wrap_up(); end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge MCLK);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge MCLK); while (ack !== 1'b1);
    r = rdat;
    cyc <= 0; stb <= 0;
  endtask : wb
  // Start an operation and poll until busy clears
  task automatic op(input logic [31:0] k);
    wb(1, 8'h00, k, q);
    do wb(0, 8'h0C, 0, q); while (q[0] !== 1'b0);
  endtask : op
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    i = $urandom(35987);
    repeat (12) @(posedge MCLK);
    SYS_RST <= 0;
    wb(0, 8'h04, 0, q); `CHK("config", 32'h0, q)
    wb(0, 8'h1C, 0, q); `CHK("unmapped", 32'h0, q)
    pr = $urandom;
    wb(1, 8'h04, {16'h0, pr, 8'h0}, q); op(1); `CHK("ip open", 1'b1, q[1])
    `CHK("proto", pr, u_dev.m[16'h4014])
    wb(1, 8'h04, 3, q); op(1); `CHK("mac open", 1'b1, q[1])
    `CHK("mode", 8'h44, u_dev.m[16'h4000])
    u_dev.refuse = 1; op(1); `CHK("retry open", 1'b1, q[1])
    u_dev.refuse = 15; op(1); `CHK("open gives up", 1'b1, q[2])
    u_dev.refuse = 0; op(9); `CHK("bad op", 1'b1, q[2])
    $display("open test done");
    len = $urandom_range(2, 12);
    wb(1, 8'h08, len, q); op(3);
    for (i = 0; i < len; i++) begin b[i] = $urandom; wb(1, 8'h10, b[i], q); op(7); end
    op(4); `CHK("sent", 1'b1, q[4])
    `CHK("event", 8'h00, u_dev.m[16'h4002])
    `CHK("tx wr", len[7:0], u_dev.m[16'h4025])
    for (i = 0; i < len; i++) `CHK("tx buf", b[i], u_dev.m[16'h8000+i])
    wb(1, 8'h0C, 32'h10, q); wb(0, 8'h0C, 0, q); `CHK("sent clr", 1'b0, q[4])
    wb(1, 8'h08, 1515, q); op(3); `CHK("too long", 1'b1, q[2])
    $display("send test done");
    u_dev.m[16'h4026] = 8'h03;
    // Record bytes in the ring; header, frame and CRC are opaque to the controller
    for (i = 0; i < len; i++) u_dev.m[16'hC000+i] = b[i] ^ 8'hA5;
    op(5); `CHK("rx low", 1'b1, q[3])
    for (i = 0; i < len; i++) begin op(8); wb(0, 8'h14, 0, q); `CHK("rx byte", b[i] ^ 8'hA5, q[7:0]) end
    `CHK("rx size", 16'h0300, q[31:16])
    op(6); `CHK("rx rd", len[7:0], u_dev.m[16'h4029])
    wb(0, 8'h18, 0, q); `CHK("pointers", {len[15:0], len[15:0]}, q)
    op(2); `CHK("closed", 8'h00, u_dev.m[16'h4003])
    $display("receive test done");
    wrap_up();
  end
endmodule : testbench
